// ==== pkg/uart_irq_pkg.sv ====
// package: register map, bit positions, reset values and timing for uart irq
package uart_irq_pkg;
	// apb byte addresses
	localparam logic [7:0] ADDR_CTRL1  = 8'h00;
	localparam logic [7:0] ADDR_CTRL2  = 8'h04;
	localparam logic [7:0] ADDR_INTERRUPT_CONTROL_REG_1  = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_PWR    = 8'h10;
	// uart_control_reg_1 bits
	localparam int CR1_UART_FUNCTION_ENABLE = 7;
	localparam int CR1_BNO    = 6;
	localparam int CR1_PARITY_ENABLE   = 5;
	// uart_control_reg_2 bits
	localparam int CR2_TXEN   = 7;
	localparam int CR2_RECEIVER_ENABLE   = 6;
	localparam int CR2_ADDRESS_DETECT_ENABLE  = 3;
	localparam int CR2_WAKE   = 2;
	localparam int CR2_RIE    = 1;
	localparam int CR2_TIIE   = 0;
	localparam int CR2_TEIE   = 4;
	// interrupt_control_reg_1 bits
	localparam int IC1_EMI    = 0;
	localparam int IC1_UART_IRQ_ENABLE   = 1;
	localparam int IC1_PEND   = 2;
	// status bits
	localparam int ST_TIDLE   = 0;
	localparam int ST_TXEMPTY = 1;
	localparam int ST_RECEIVE_DATA_AVAILABLE_FLAG    = 2;
	localparam int ST_OERR    = 3;
	localparam int ST_RESUME  = 4;
	localparam int ST_PDOWN   = 5;
	// reset values
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] INTERRUPT_CONTROL_REG_1_RST = 8'h00;
	// resume delay after rx wake-up
	localparam int RESUME_CYCLES = 1024;
	localparam int RESUME_W      = 11;
	typedef enum logic [1:0] {RUN, SLEEP, RESUME} pwr_t;
endpackage

// ==== hdl/rx_pin_sync.sv ====
// three-flop pin synchroniser with agreement filter for the rx pin
`timescale 1ns/10ps
module rx_pin_sync (
	// clock and reset
	input  wire logic clock,
	input  wire logic rstn,
	// pin and filtered level
	input  wire logic pinIn,
	output logic      level
);
	logic s1_r;
	logic s2_r;
	logic s3_r;

	// idle line is high, so reset to one
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s1_r  <= 1'b1;
			s2_r  <= 1'b1;
			s3_r  <= 1'b1;
			level <= 1'b1;
		end else begin
			s1_r <= pinIn;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
				level <= s3_r;
		end
	end
endmodule // rx_pin_sync

// ==== hdl/uart_irq_wakeup.sv ====
// uart interrupt merge, address detect and power-down wake-up logic
`timescale 1ns/10ps
// Notes on behaviour
// - all uart sources merge into one request with its own vector strobe
// - four status flags raise the request only when enabled in control 2
// - tx empty and tx idle own enables; rx data and overrun share one
// - address detect has no flag; raises request when its enable set
// - rx wake raises request when wake and rx interrupt enables set
// - after wake wait 1024 cycles, ignore rx pin, hold interrupt
// - status flags read-only; vectoring does not clear them
// - request gated by uart interrupt enable and global enable
// - vector taken only while call stack is not full
// - address detect needs top received bit high, bit 9 or bit 8
// - without address detect every rx flag set gives interrupt
// - power-down stops uart clocks, aborts tx, drives tx high
// - power-down abandons a reception in progress
// - power-down leaves all registers unchanged
// - falling rx edge wakes chip when four enables all set
// - wake without global or uart enable gives no interrupt
// - rx data flag set while buffer holds an unread character
// - overrun also raises request under shared rx enable
module uart_irq_wakeup
	import uart_irq_pkg::*;
#(
	parameter int RESUME_LEN = RESUME_CYCLES
) (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rstn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// uart core status
	input  wire logic        txEmpty,
	input  wire logic        txIdle,
	input  wire logic        rxUnread,
	input  wire logic        rxOverrun,
	input  wire logic        rxWordDone,
	input  wire logic [8:0]  rxWord,
	input  wire logic        txBusy,
	input  wire logic        rxBusy,
	// cpu side
	input  wire logic        powerDownReq,
	input  wire logic        stackFull,
	input  wire logic        vectorAck,
	// pins
	input  wire logic        rxPin,
	output logic             rxPinOk,
	output logic             txForceHigh,
	output logic             txAbort,
	output logic             rxAbort,
	// uart clock gating and system wake
	output logic             uartClkEn,
	output logic             cpuWake,
	output logic             irqReq,
	output logic             vectorJump
);
	logic [7:0]          ctrl1_r;
	logic [7:0]          ctrl2_r;
	logic [7:0]          interrupt_control_reg_1_r;
	logic                addrHit_r;
	logic                wakeHit_r;
	logic                rxLevelD_r;
	logic                pdArmed_r;
	logic [RESUME_W-1:0] resumeCnt_r;
	logic [RESUME_W-1:0] resumeCnt_nxt;
	pwr_t                pwr_r;
	pwr_t                pwr_nxt;
	logic                rxLevel;
	logic                rxFall;
	logic                wakeArmed;
	logic                topBit;
	logic                srcTxEmpty;
	logic                srcTxIdle;
	logic                srcRxData;
	logic                srcOverrun;
	logic                srcAddr;
	logic                srcWake;
	logic                anySrc;
	logic                gatedReq;
	logic                wrEn;
	logic                rdEn;
	logic                addrOk;
	logic [7:0]          statusVal;
	logic [31:0]         rdData;
	logic                inResume;
	logic                resumeDone;
	logic                wrCtrl1;
	logic                wrCtrl2;
	logic                wrIntc1;
	logic                inRun;
	logic                inSleep;
	logic                enterPd;
	logic                wakeEvt;
	logic                runNext;
	logic                jump_nxt;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	rx_pin_sync u_rx_sync (
		.clock (clock),
		.rstn  (rstn),
		.pinIn (rxPin),
		.level (rxLevel)
	);

	// apb decode, zero wait states
	assign wrEn   = psel && penable && pwrite;
	assign rdEn   = psel && !penable && !pwrite;
	assign addrOk = hit(paddr, ADDR_CTRL1) || hit(paddr, ADDR_CTRL2) ||
		hit(paddr, ADDR_INTERRUPT_CONTROL_REG_1) || hit(paddr, ADDR_STATUS) ||
		hit(paddr, ADDR_PWR);
	// one strobe per register keeps the update blocks small
	assign wrCtrl1 = wrEn && hit(paddr, ADDR_CTRL1);
	assign wrCtrl2 = wrEn && hit(paddr, ADDR_CTRL2);
	assign wrIntc1 = wrEn && hit(paddr, ADDR_INTERRUPT_CONTROL_REG_1);

	// bits 3:0 come straight from the uart core, bits 5:4 from the power state; software cannot write them
	assign statusVal = {2'b00, pwr_r == SLEEP, inResume, rxOverrun,
		rxUnread, txEmpty, txIdle};

	assign rdData =
		hit(paddr, ADDR_CTRL1)  ? {24'h000000, ctrl1_r} :
		hit(paddr, ADDR_CTRL2)  ? {24'h000000, ctrl2_r} :
		hit(paddr, ADDR_INTERRUPT_CONTROL_REG_1)  ? {24'h000000, interrupt_control_reg_1_r[7:3], irqReq,
			interrupt_control_reg_1_r[1:0]} :
		hit(paddr, ADDR_STATUS) ? {24'h000000, statusVal} :
		hit(paddr, ADDR_PWR)    ? {30'h00000000, pwr_r == RESUME,
			pwr_r == SLEEP} : 32'h00000000;

	// power state
	assign inResume   = pwr_r == RESUME;
	assign resumeDone = resumeCnt_r == RESUME_W'(RESUME_LEN - 1);
	assign wakeArmed  = ctrl2_r[CR2_WAKE] && ctrl1_r[CR1_UART_FUNCTION_ENABLE] &&
		ctrl2_r[CR2_RECEIVER_ENABLE] && ctrl2_r[CR2_RIE];
	assign rxFall     = rxLevelD_r && !rxLevel;
	assign inRun      = pwr_r == RUN;
	assign inSleep    = pwr_r == SLEEP;
	assign enterPd    = inRun && powerDownReq;
	assign wakeEvt    = inSleep && pwr_nxt == RESUME;
	assign runNext    = pwr_nxt == RUN;

	always_comb begin
		pwr_nxt       = pwr_r;
		resumeCnt_nxt = resumeCnt_r;
		case (pwr_r)
			RUN: begin
				if (powerDownReq)
					pwr_nxt = SLEEP;
			end
			SLEEP: begin
				if (pdArmed_r && rxFall) begin
					pwr_nxt       = RESUME;
					resumeCnt_nxt = '0;
				end
			end
			RESUME: begin
				resumeCnt_nxt = resumeCnt_r + 1'b1;
				if (resumeDone)
					pwr_nxt = RUN;
			end
			default: pwr_nxt = RUN;
		endcase
	end

	// interrupt sources
	assign topBit     = ctrl1_r[CR1_BNO] ? rxWord[8] : rxWord[7];
	assign srcTxEmpty = txEmpty && ctrl2_r[CR2_TEIE];
	assign srcTxIdle  = txIdle && ctrl2_r[CR2_TIIE];
	assign srcRxData  = rxUnread && ctrl2_r[CR2_RIE] &&
		!ctrl2_r[CR2_ADDRESS_DETECT_ENABLE];
	assign srcOverrun = rxOverrun && ctrl2_r[CR2_RIE];
	assign srcAddr    = addrHit_r && ctrl2_r[CR2_ADDRESS_DETECT_ENABLE];
	assign srcWake    = wakeHit_r && ctrl2_r[CR2_WAKE] &&
		ctrl2_r[CR2_RIE];
	assign anySrc     = srcTxEmpty || srcTxIdle || srcRxData ||
		srcOverrun || srcAddr || srcWake;
	// interrupt held off while asleep or resuming
	assign gatedReq   = anySrc && interrupt_control_reg_1_r[IC1_UART_IRQ_ENABLE] && interrupt_control_reg_1_r[IC1_EMI] &&
		pwr_r == RUN;
	// single pulse; a stack full cycle simply retries later
	assign jump_nxt   = gatedReq && !stackFull && !vectorJump &&
		!vectorAck;

	// control registers keep contents across power-down
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			ctrl1_r <= CTRL1_RST;
		else if (wrCtrl1)
			ctrl1_r <= pwdata[7:0];
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			ctrl2_r <= CTRL2_RST;
		else if (wrCtrl2)
			ctrl2_r <= pwdata[7:0];
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			interrupt_control_reg_1_r <= INTERRUPT_CONTROL_REG_1_RST;
		else if (wrIntc1)
			interrupt_control_reg_1_r <= pwdata[7:0];
	end

	// address match is an event: held until vectored, set wins over clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			addrHit_r <= 1'b0;
		else if (rxWordDone && topBit && pwr_r == RUN &&
			ctrl2_r[CR2_ADDRESS_DETECT_ENABLE])
			addrHit_r <= 1'b1;
		else if (vectorAck || !ctrl2_r[CR2_ADDRESS_DETECT_ENABLE])
			addrHit_r <= 1'b0;
	end

	// wake event waits out the resume interval before it may interrupt
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			wakeHit_r <= 1'b0;
		else if (pwr_r == SLEEP && pwr_nxt == RESUME)
			wakeHit_r <= interrupt_control_reg_1_r[IC1_EMI] && interrupt_control_reg_1_r[IC1_UART_IRQ_ENABLE];
		else if (vectorAck && pwr_r == RUN)
			wakeHit_r <= 1'b0;
	end

	// power state and resume counter
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pwr_r       <= RUN;
			resumeCnt_r <= '0;
		end else begin
			pwr_r       <= pwr_nxt;
			resumeCnt_r <= resumeCnt_nxt;
		end
	end

	// enables sampled as sleep begins
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			pdArmed_r <= 1'b0;
		else if (enterPd)
			pdArmed_r <= wakeArmed;
	end

	// idle level is high, so no false edge follows reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			rxLevelD_r <= 1'b1;
		else
			rxLevelD_r <= rxLevel;
	end

	// apb answer: zero wait states, read data taken at setup
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addrOk;
			if (rdEn)
				prdata <= addrOk ? rdData : 32'h00000000;
		end
	end

	// interrupt request and vector strobe
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irqReq     <= 1'b0;
			vectorJump <= 1'b0;
		end else begin
			irqReq     <= gatedReq;
			vectorJump <= jump_nxt;
		end
	end

	// power-down controls; uart clocks run through reset
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			uartClkEn   <= 1'b1;
			txForceHigh <= 1'b0;
			txAbort     <= 1'b0;
			rxAbort     <= 1'b0;
			cpuWake     <= 1'b0;
			rxPinOk     <= 1'b1;
		end else begin
			uartClkEn   <= runNext;
			txForceHigh <= !runNext;
			txAbort     <= enterPd && txBusy;
			rxAbort     <= enterPd && rxBusy;
			cpuWake     <= wakeEvt;
			rxPinOk     <= runNext;
		end
	end
endmodule // uart_irq_wakeup

// ==== sim/uart_irq_wakeup_asserts.sv ====
// port assertions for the uart interrupt and wake-up block
`timescale 1ns/10ps
module uart_irq_wakeup_asserts #(parameter int RESUME_LEN = 16) (
	// clock, reset and inputs
	input wire logic clock, rstn, powerDownReq, stackFull, txBusy, rxBusy,
	// outputs
	input wire logic vectorJump, irqReq, uartClkEn, txForceHigh,
	input wire logic txAbort, rxAbort, rxPinOk, cpuWake
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	int   cnt_r;
	logic woke_r;
	// cycles since the last wake, to bound the blocked interval
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_r  <= 0;
			woke_r <= 1'h0;
		end else begin
			cnt_r  <= cpuWake ? 0 : cnt_r + 1;
			woke_r <= cpuWake | (woke_r & !rxPinOk);
		end
	end
	sequence s_enter;
		powerDownReq && uartClkEn && !txForceHigh;
	endsequence
	property p_vgate; vectorJump |-> irqReq && !$past(stackFull); endproperty
	property p_vpulse; vectorJump |=> !vectorJump; endproperty
	property p_sleep;
		s_enter |=> !uartClkEn && txForceHigh && !rxPinOk;
	endproperty
	property p_txab; s_enter ##0 txBusy |=> txAbort; endproperty
	property p_rxab; s_enter ##0 rxBusy |=> rxAbort; endproperty
	property p_hold; !rxPinOk && $past(!rxPinOk) |-> !irqReq; endproperty
	property p_wake; cpuWake |-> !rxPinOk ##1 !rxPinOk [*3]; endproperty
	property p_len;
		$rose(rxPinOk) && woke_r |-> cnt_r inside {[RESUME_LEN-2:RESUME_LEN+3]};
	endproperty
	a_vgate: assert property (p_vgate) else $error("ungated jump");
	a_vpulse: assert property (p_vpulse) else $error("jump width");
	a_sleep: assert property (p_sleep) else $error("no sleep");
	a_txab: assert property (p_txab) else $error("no tx abort");
	a_rxab: assert property (p_rxab) else $error("no rx abort");
	a_hold: assert property (p_hold) else $error("irq while held");
	a_wake: assert property (p_wake) else $error("rx not blocked");
	a_len: assert property (p_len) else $error("resume length");
endmodule // uart_irq_wakeup_asserts
bind uart_irq_wakeup uart_irq_wakeup_asserts #(.RESUME_LEN(RESUME_LEN)) i_chk (
	.clock(clock), .rstn(rstn), .powerDownReq(powerDownReq),
	.stackFull(stackFull), .txBusy(txBusy), .rxBusy(rxBusy),
	.vectorJump(vectorJump), .irqReq(irqReq), .uartClkEn(uartClkEn),
	.txForceHigh(txForceHigh), .txAbort(txAbort), .rxAbort(rxAbort),
	.rxPinOk(rxPinOk), .cpuWake(cpuWake));

// ==== sim/rx_line_model.sv ====
// remote transmitter: line idles high, low for lowLen cycles per send
`timescale 1ns/10ps
module rx_line_model (
	// clock, reset and command
	input wire logic       clock, rstn, send,
	input wire logic [7:0] lowLen,
	// serial line
	output logic           rxLine
);
	logic [7:0] cnt_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			cnt_r <= 8'h00;
		else if (send)
			cnt_r <= lowLen;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
	end
	assign rxLine = (cnt_r == 8'h00);
endmodule // rx_line_model

// ==== sim/tb_top.sv ====
// self-checking bench for the uart interrupt and wake-up block
`timescale 1ns/10ps
module tb_top
	import uart_irq_pkg::*;
;
	logic clock = '0, rstn = '0, psel = '0, penable = '0, pwrite = '0;
	logic txEmpty = '0, txIdle = '0, rxUnread = '0, rxOverrun = '0;
	logic rxWordDone = '0, txBusy = '0, rxBusy = '0, powerDownReq = '0;
	logic stackFull = '0, vectorAck = '0, send = '0;
	logic [7:0] paddr = '0, lowLen = 8'h08;
	logic [8:0] rxWord = '0;
	logic [31:0] pwdata = '0, seed = 32'h33ae, prdata;
	logic pready, pslverr, rxLine, rxPinOk, cpuWake;
	logic [32:0] expQ[$];
	int nFail = 0, checksDone = 0;
	uart_irq_wakeup #(.RESUME_LEN(16)) i_dut (.clock(clock), .rstn(rstn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.txEmpty(txEmpty), .txIdle(txIdle), .rxUnread(rxUnread),
		.rxOverrun(rxOverrun), .rxWordDone(rxWordDone), .rxWord(rxWord),
		.txBusy(txBusy), .rxBusy(rxBusy), .powerDownReq(powerDownReq),
		.stackFull(stackFull), .vectorAck(vectorAck), .rxPin(rxLine),
		.rxPinOk(rxPinOk), .txForceHigh(), .txAbort(), .rxAbort(),
		.uartClkEn(), .cpuWake(cpuWake), .irqReq(), .vectorJump());
	rx_line_model i_line (.clock(clock), .rstn(rstn), .send(send),
		.lowLen(lowLen), .rxLine(rxLine));
	always #25 clock = ~clock;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		checksDone++;
		if (seen !== want) begin
			nFail++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic completeRun();
		$display("comparisons %0d mismatches %0d", checksDone, nFail);
		if (nFail == 0 && checksDone > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// read results are noted here and compared by the monitor below
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [32:0] e);
		int n;
		n = 0;
		if (!w)
			expQ.push_back(e);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'h1 && n < 16);
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			nFail++;
			completeRun();
		end
	endtask
	task automatic pulse(int k);
		@(posedge clock);
		case (k)
			0: rxWordDone <= 1'h1;
			1: vectorAck <= 1'h1;
			2: powerDownReq <= 1'h1;
			default: send <= 1'h1;
		endcase
		@(posedge clock);
		{rxWordDone, vectorAck, powerDownReq, send} <= '0;
	endtask
	task automatic waitHigh(int k);
		int n;
		n = 0;
		while ((k ? rxPinOk : cpuWake) !== 1'h1 && n < 400) begin
			@(posedge clock);
			n++;
		end
		if (n == 400) begin
			nFail++;
			completeRun();
		end
	endtask
	always @(posedge clock)
		if (psel && penable && pready === 1'h1 && !pwrite)
			check({pslverr, prdata}, expQ.pop_front());
	initial begin
		logic [31:0] c2, ic;
		logic hit;
		repeat (10) @(posedge clock);
		rstn <= 1'h1;
		apb(0, ADDR_CTRL2, 0, 33'h0);
		apb(0, 8'h14, 0, {1'h1, 32'h0});
		apb(1, ADDR_STATUS, 32'hff, 0);
		apb(0, ADDR_STATUS, 0, 33'h0);
		$display("test map done");
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			{txIdle, txEmpty, rxUnread, rxOverrun} <= seed[3:0];
			stackFull <= seed[4];
			c2 = {27'h0, seed[8], 2'h0, seed[9], seed[10]};
			ic = {30'h0, seed[12:11]};
			hit = seed[3] & c2[0] | seed[2] & c2[4] | (|seed[1:0]) & c2[1];
			apb(1, ADDR_CTRL2, c2, 0);
			apb(1, ADDR_INTERRUPT_CONTROL_REG_1, ic, 0);
			apb(0, ADDR_STATUS, 0, {29'h0, seed[0], seed[1], seed[2], seed[3]});
			apb(0, ADDR_INTERRUPT_CONTROL_REG_1, 0, {30'h0, hit & (&ic[1:0]), ic[1:0]});
		end
		{txIdle, txEmpty, rxOverrun, stackFull, rxUnread} <= 5'h01;
		apb(1, ADDR_INTERRUPT_CONTROL_REG_1, 32'h3, 0);
		for (int k = 0; k < 4; k++) begin
			rxWord <= k[0] ? 9'h100 : 9'h080;
			apb(1, ADDR_CTRL1, {24'h0, 1'h1, k[1], 6'h0}, 0);
			apb(1, ADDR_CTRL2, 32'h4a, 0);
			pulse(0);
			apb(0, ADDR_STATUS, 0, 33'h4);
			apb(0, ADDR_INTERRUPT_CONTROL_REG_1, 0, {30'h0, k[1] == k[0], 2'h3});
			pulse(1);
			apb(1, ADDR_CTRL2, 32'h42, 0);
			apb(0, ADDR_STATUS, 0, 33'h4);
			apb(0, ADDR_INTERRUPT_CONTROL_REG_1, 0, 33'h7);
		end
		$display("test address detect done");
		{rxUnread, txBusy, rxBusy} <= 3'h3;
		for (int m = 0; m < 2; m++) begin
			apb(1, ADDR_INTERRUPT_CONTROL_REG_1, {30'h0, m == 0, 1'h1}, 0);
			apb(1, ADDR_CTRL1, 32'h80, 0);
			apb(1, ADDR_CTRL2, 32'h46, 0);
			pulse(2);
			apb(0, ADDR_PWR, 0, 33'h1);
			apb(0, ADDR_CTRL2, 0, 33'h46);
			lowLen <= m ? 8'h30 : 8'h08;
			pulse(3);
			waitHigh(0);
			apb(0, ADDR_PWR, 0, 33'h2);
			waitHigh(1);
			apb(0, ADDR_STATUS, 0, 33'h0);
			apb(0, ADDR_INTERRUPT_CONTROL_REG_1, 0, {30'h0, m == 0, m == 0, 1'h1});
			pulse(1);
		end
		$display("test power-down done");
		completeRun();
	end
endmodule // tb_top
